// ===== hdl/efd_drive.sv
// One external floppy drive: select decode, motor latch, head, status lines
`timescale 1ns/1ps

module efd_drive
  import efd_pkg::*;
#(
  parameter logic [15:0] DRIVE_ID   = ID_DD_48TPI,  // Identifier shifted out on ready
  parameter int          REV_CYC    = REV_CYCLES,   // Clocks per revolution
  parameter int          INDEX_CYC  = INDEX_CYCLES, // Clocks of index low
  parameter int          SPINUP_CYC = SPINUP_CYCLES // Clocks from motor on to ready
) (
  input  wire logic       clk,        // System clock
  input  wire logic       rst,        // Power-up reset
  input  wire efd_host_s  host,       // Cable inputs
  input  wire efd_media_s media,      // Mechanism state
  output efd_stat_s       stat_o,     // Open-drain levels (value when driven)
  output efd_stat_s       stat_oe_n,  // Output enables, low while driving
  output logic            motor_on,   // Spindle motor command
  output logic            head_side,  // Selected head, 1 means side one
  output logic [6:0]      track,      // Current head track
  output logic            write_en,   // Recording enabled
  output logic            write_bit   // Bit passed to the write head
);

  // ==========================================================================
  // State
  typedef enum {EFD_IDLE, EFD_ARMED} efd_id_e;

  logic        sel_q, next_sel_q;
  logic        step_q, next_step_q;
  logic        motor, next_motor;
  logic [6:0]  trk, next_trk;
  logic        chg, next_chg;
  logic [31:0] rev_cnt, next_rev_cnt;
  logic [31:0] spin_cnt, next_spin_cnt;
  logic [15:0] id_sh, next_id_sh;
  efd_id_e     id_st, next_id_st;
  efd_stat_s   next_stat_o, next_oe_n;
  logic        next_side, next_wen, next_wbit;

  logic sel, sel_fall, sel_rise, step_fall, at_speed;

  assign sel       = ~host.select_n;
  assign sel_fall  = sel & ~sel_q;
  assign sel_rise  = ~sel & sel_q;
  assign step_fall = sel & ~host.head_move_pulse_n & step_q;
  assign at_speed  = motor && (spin_cnt >= 32'(SPINUP_CYC));

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_sel_q    = sel;
    next_step_q   = host.head_move_pulse_n;
    next_motor    = motor;
    next_trk      = trk;
    next_chg      = chg;
    next_rev_cnt  = rev_cnt;
    next_spin_cnt = spin_cnt;
    next_id_sh    = id_sh;
    next_id_st    = id_st;
    // Motor flop loads on select falling edge
    if (sel_fall) begin
      next_motor = ~host.shared_spindle_on_n;
    end
    if (!host.drive_reset_n) begin
      next_motor = MOTOR_RESET;
    end
    // Head stepping
    if (step_fall) begin
      if (!host.head_move_way) begin
        if (trk != LAST_TRACK) next_trk = trk + 7'h01;
      end else begin
        if (trk != OUTER_TRACK) next_trk = trk - 7'h01;
      end
    end
    // Change latch: set wins over clear
    if (step_fall && media.present) next_chg = 1'b0;
    if (!media.present) next_chg = 1'b1;
    // Revolution and spin-up counters
    if (motor && media.present) begin
      next_rev_cnt = (rev_cnt >= 32'(REV_CYC - 1)) ? 32'h0 : rev_cnt + 32'h1;
      if (!at_speed) next_spin_cnt = spin_cnt + 32'h1;
    end else begin
      next_rev_cnt  = 32'h0;
      next_spin_cnt = 32'h0;
    end
    // ID shifter: a motor-off latch while idle arms and reloads, each deselect while armed advances
    case (id_st)
      EFD_IDLE: begin
        if (sel_fall && host.shared_spindle_on_n) begin
          // Loaded rotated right so that the shift on the next deselect puts the MSB first
          next_id_sh = {DRIVE_ID[0], DRIVE_ID[15:1]};
          next_id_st = EFD_ARMED;
        end
      end
      EFD_ARMED: begin
        if (sel_rise) next_id_sh = {id_sh[14:0], id_sh[15]};
        if (sel_fall && !host.shared_spindle_on_n) next_id_st = EFD_IDLE;
      end
      default: next_id_st = EFD_IDLE;
    endcase
    // Look at the motor as loaded at this edge, so the motor-off select can still arm
    if (next_motor) next_id_st = EFD_IDLE;
  end

  // Status line values, driven only while selected
  always_comb begin
    next_stat_o = '0;
    next_oe_n   = '1;
    if (sel) begin
      next_oe_n.head_at_outer_track_n = ~(trk == OUTER_TRACK);
      next_oe_n.write_protected_n     = ~(media.present & media.protect);
      next_oe_n.index_n = ~(motor && media.present
                            && rev_cnt < 32'(INDEX_CYC));
      next_oe_n.media_swapped_n = ~chg;
      next_oe_n.read_stream_n   = ~(motor & media.present & ~media.read_bit);
      // Ready: speed when motor on, ID bit (low for 1) when off
      if (motor) next_oe_n.ready_n = ~(at_speed & media.present);
      else       next_oe_n.ready_n = ~id_sh[15];
    end
    next_side = ~host.head_side_n;
    next_wen  = sel & ~host.write_gate_n & host.drive_reset_n
                & media.present & ~media.protect;
    next_wbit = next_wen & ~host.write_stream_n;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q     <= 1'b0;
      step_q    <= 1'b1;
      motor     <= MOTOR_RESET;
      trk       <= OUTER_TRACK;
      chg       <= 1'b1;  // Set at power-up
      rev_cnt   <= 32'h0;
      spin_cnt  <= 32'h0;
      id_sh     <= 16'h0;
      id_st     <= EFD_IDLE;
      stat_o    <= '0;
      stat_oe_n <= '1;
      motor_on  <= 1'b0;
      head_side <= 1'b0;
      track     <= OUTER_TRACK;
      write_en  <= 1'b0;
      write_bit <= 1'b0;
    end else begin
      sel_q     <= next_sel_q;
      step_q    <= next_step_q;
      motor     <= next_motor;
      trk       <= next_trk;
      chg       <= next_chg;
      rev_cnt   <= next_rev_cnt;
      spin_cnt  <= next_spin_cnt;
      id_sh     <= next_id_sh;
      id_st     <= next_id_st;
      stat_o    <= next_stat_o;
      stat_oe_n <= next_oe_n;
      motor_on  <= next_motor;
      head_side <= next_side;
      track     <= next_trk;
      write_en  <= next_wen;
      write_bit <= next_wbit;
    end
  end

endmodule : efd_drive

// ===== hdl/efd_pkg.sv
// Package for the external floppy drive side of the shared disk cable
package efd_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ         = 200;
  localparam int REV_PERIOD_US   = 200000;          // One spindle revolution (300 rpm)
  localparam int REV_CYCLES      = REV_PERIOD_US * CLK_MHZ;
  localparam int INDEX_PULSE_US  = 2;               // Low time of the index pulse
  localparam int INDEX_CYCLES    = INDEX_PULSE_US * CLK_MHZ;
  localparam int SPINUP_US       = 500000;          // Motor on to ready
  localparam int SPINUP_CYCLES   = SPINUP_US * CLK_MHZ;

  // ==========================================================================
  // Geometry and identification
  localparam int          TRACK_W       = 7;
  localparam logic [6:0]  OUTER_TRACK   = 7'h00;
  localparam logic [6:0]  LAST_TRACK    = 7'h4f;
  localparam logic [15:0] ID_DD_48TPI   = 16'h5555;  // Double density, double sided
  localparam logic [15:0] ID_USER_PFX   = 16'h0f00;  // User range prefix
  localparam logic [15:0] ID_EXT_PFX    = 16'hf000;  // Extension prefix
  localparam logic        MOTOR_RESET   = 1'b0;

  // ==========================================================================
  // Signals from the host, all active low except the head move way
  typedef struct packed {
    logic select_n;
    logic shared_spindle_on_n;
    logic head_side_n;
    logic head_move_pulse_n;
    logic head_move_way;
    logic write_stream_n;
    logic write_gate_n;
    logic drive_reset_n;
  } efd_host_s;

  // Open-drain status lines returned to the host
  typedef struct packed {
    logic head_at_outer_track_n;
    logic ready_n;
    logic write_protected_n;
    logic index_n;
    logic read_stream_n;
    logic media_swapped_n;
  } efd_stat_s;

  // Media state from the mechanism
  typedef struct packed {
    logic present;
    logic protect;
    logic read_bit;
  } efd_media_s;

endpackage : efd_pkg

// ===== test/efd_drive_asserts.sv
// Assertion checker on the ports of one external floppy drive
`timescale 1ns/1ps
module efd_drive_asserts
  import efd_pkg::*;
(
  input wire logic       clk,       // System clock
  input wire logic       rst,       // Power-up reset
  input wire efd_host_s  host,      // Cable inputs
  input wire efd_media_s media,     // Mechanism state
  input wire efd_stat_s  stat_oe_n, // Line enables
  input wire logic       motor_on,  // Motor flop
  input wire logic [6:0] track,     // Head track
  input wire logic       write_en   // Recording on
);
  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence sel_fall;
    $fell(host.select_n) && host.drive_reset_n;
  endsequence
  a_desel_quiet: assert property (host.select_n |=> stat_oe_n == 6'h3f)
    else $error("status line driven while deselected");
  a_motor_load: assert property (sel_fall |=> motor_on == !$past(host.shared_spindle_on_n))
    else $error("motor flop did not load on select");
  a_reset_motor: assert property (!host.drive_reset_n |=> !motor_on && !write_en)
    else $error("drive reset did not stop motor or writes");
  a_write_gate: assert property (host.select_n || host.write_gate_n |=> !write_en)
    else $error("recording without select and gate");
  a_protect_line: assert property (!host.select_n && media.present && media.protect
    |=> !stat_oe_n.write_protected_n)
    else $error("protect line not pulled");
  a_step_move: assert property ($fell(host.head_move_pulse_n) && !host.select_n
    && track > 7'h00 && track < 7'h4f |=> track == ($past(host.head_move_way) ?
    $past(track) - 7'h01 : $past(track) + 7'h01))
    else $error("head moved the wrong way");
  a_change_line: assert property (!host.select_n && !media.present ##1 !host.select_n
    |=> !stat_oe_n.media_swapped_n)
    else $error("change line not pulled without media");
  a_outer_line: assert property (!host.select_n && track == 7'h00 && $stable(track)
    |=> !stat_oe_n.head_at_outer_track_n)
    else $error("outer track line not pulled");
endmodule : efd_drive_asserts

bind efd_drive efd_drive_asserts i_efd_drive_asserts (.clk(clk), .rst(rst), .host(host),
  .media(media), .stat_oe_n(stat_oe_n), .motor_on(motor_on), .track(track),
  .write_en(write_en));

// ===== test/efd_host_model.sv
// Host end of the cable: pull-ups on the drive's open-drain lines
`timescale 1ns/1ps
module efd_host_model
  import efd_pkg::*;
(
  input  wire efd_stat_s stat_o,    // Driven values
  input  wire efd_stat_s stat_oe_n, // Enables, low while driving
  output efd_stat_s      line       // Level seen on the cable
);
  // Released lines float up to the pull-up level
  assign line = stat_oe_n | stat_o;
endmodule : efd_host_model

// ===== test/testbench.sv
// Self-checking bench for one external floppy drive
`timescale 1ns/1ps
module testbench import efd_pkg::*;;
  logic       clk, rst, motor_on, head_side, write_en, write_bit, ix;
  efd_host_s  h;
  efd_media_s m;
  efd_stat_s  so, soe, line;
  logic [6:0] track;
  logic [15:0] id;
  int         mismatches, checks_done, n, k;
  logic [8:0] rows [5] = '{9'h003, 9'h005, 9'h103, 9'h100, 9'h100};
  // ==========================================================================
  // Design and host end
  efd_drive #(.DRIVE_ID(16'h0f3c), .REV_CYC(100), .INDEX_CYC(5), .SPINUP_CYC(20)) i_efd_drive (
    .clk(clk), .rst(rst), .host(h), .media(m), .stat_o(so), .stat_oe_n(soe),
    .motor_on(motor_on), .head_side(head_side), .track(track), .write_en(write_en),
    .write_bit(write_bit));
  efd_host_model i_efd_host_model (.stat_o(so), .stat_oe_n(soe), .line(line));
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic sel(input logic v, input int c);
    @(posedge clk);
    h.select_n <= v;
    repeat (c) @(posedge clk);
  endtask : sel
  task automatic step(input logic way);
    @(posedge clk);
    h.head_move_way <= way; // Direction set ahead of the pulse
    @(posedge clk);
    h.head_move_pulse_n <= 1'b0;
    repeat (2) @(posedge clk);
    h.head_move_pulse_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : step
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ==========================================================================
  // Main sequence
  initial begin
    {mismatches, checks_done} = '0;
    rst = 1'b1;
    h = 8'hff;
    m = 3'b100;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({motor_on, track, line}, {1'b0, 7'h00, 6'h3f});
    sel(1'b0, 3);
    @(negedge clk);
    chk({line.media_swapped_n, line.head_at_outer_track_n}, 16'h0);
    for (n = 0; n < 5; n++) begin
      step(rows[n][8]);
      @(negedge clk);
      chk({track, line.head_at_outer_track_n}, rows[n][7:0]);
    end
    chk(line.media_swapped_n, 1'b1);
    $display("step test done");
    @(posedge clk);
    m <= 3'b110;
    h.write_gate_n <= 1'b0;
    h.head_side_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk({line.write_protected_n, write_en, head_side}, 3'b001);
    m <= 3'b000;
    repeat (3) @(posedge clk);
    chk(line.media_swapped_n, 1'b0);
    m <= 3'b100;
    h.write_stream_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(write_en, 1'b1);
    chk(write_bit, 1'b1);
    h.write_stream_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(write_bit, 1'b0);
    sel(1'b1, 3);
    chk({write_en, line}, {1'b0, 6'h3f});
    $display("write test done");
    h.shared_spindle_on_n <= 1'b0; // Set while deselected
    repeat (290) @(posedge clk); // Setup over 1.4 us
    sel(1'b0, 290); // Hold over 1.4 us
    h.shared_spindle_on_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({motor_on, line.ready_n}, 2'b10);
    chk(line.read_stream_n, 1'b0);
    m <= 3'b101;
    repeat (3) @(posedge clk);
    chk(line.read_stream_n, 1'b1);
    m <= 3'b100;
    k = 0;
    repeat (300) begin
      ix = line.index_n;
      @(negedge clk);
      if (ix && !line.index_n) k++;
    end
    chk(k[15:0], 16'h3);
    @(posedge clk);
    h.write_gate_n <= 1'b0;
    h.drive_reset_n <= 1'b0; // Drive reset pulse from the host
    repeat (2) @(posedge clk);
    chk({motor_on, write_en}, 2'b00);
    h.drive_reset_n <= 1'b1;
    h.write_gate_n <= 1'b1;
    $display("motor test done");
    sel(1'b1, 290);
    h.shared_spindle_on_n <= 1'b0; // Identification steps in order
    repeat (290) @(posedge clk);
    sel(1'b0, 290);
    sel(1'b1, 4);
    h.shared_spindle_on_n <= 1'b1;
    repeat (290) @(posedge clk);
    sel(1'b0, 290);
    sel(1'b1, 4);
    for (n = 0; n < 16; n++) begin
      sel(1'b0, 4); // Settle time before the sample
      @(negedge clk);
      id[15 - n] = ~line.ready_n;
      sel(1'b1, 4);
    end
    chk(id, 16'h0f3c);
    $display("identification test done");
    test_done();
  end
endmodule : testbench
